// ---- hdl/pdcs_decode.sv ----
// Peripheral chip-select decode with its APB configuration registers.
// Assumes requests are synchronous to pclk and APB obeys its protocol.
// How it works
// - Config RAM bit decodes 0C00h writes, 0800h-08FFh
// - 0C00h gives page select, 08xxh memory select
// - Config RAM bit clear blocks both selects
// - Bit 6 enables port 92, reset one
// - Bits 5:4 pick parallel range, reset 00
// - Bits 3:2 pick serial B range, reset 11
// - Bits 1:0 pick serial A range, reset 11
// - Serial B suppressed when sharing A's range
// - Disabled peripheral gets no select, no OE
// - Read-allow bit lets segment reads select memory
// - Write-allow bit lets segment writes select memory
// - No allow bits or control off: no select
// - Register 54h covers C0000h-CFFFFh, low pair first
// - Register 55h covers D0000h-DFFFFh, low pair first
// - Register 56h covers E0000h-EFFFFh, low pair first
// - Relocation register gives S/G I/O A15..A8
`timescale 1ns/1ns
`default_nettype none

module pdcs_decode
    import pdcs_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire pdcs_access_t access_req,
    output logic      [2:0]   encoded_device_select,
    output logic              utility_transceiver_oe_n,
    output logic              config_page_select_n,
    output logic              config_memory_select_n,
    output logic              main_memory_select_n,
    output logic              sg_register_select,
    output logic      [7:0]   sg_io_base
);

    // Serial range hit for one 2-bit field; reserved codes never hit
    function automatic logic com_hit(input logic [1:0]  sel,
                                     input logic [15:0] a);
        case (sel)
            COM_RANGE1: com_hit = (a[15:3] == IO_COM1_BLK);
            COM_RANGE2: com_hit = (a[15:3] == IO_COM2_BLK);
            default:    com_hit = 1'b0;
        endcase
    endfunction

    // Configuration registers
    logic [7:0] psel_b_r;
    logic [7:0] mattr_c_r;
    logic [7:0] mattr_d_r;
    logic [7:0] mattr_e_r;
    logic [7:0] sg_base_r;
    logic [7:0] msel_ctrl_r;
    logic [31:0] prdata_r;

    // APB decode; registers sit in byte lane 0
    wire logic [7:0] reg_idx   = paddr[9:2];
    wire logic       hit_psel  = (paddr[11:10] == 2'b00)
                                 && (reg_idx == IDX_PSEL_B);
    wire logic       hit_mc    = (paddr[11:10] == 2'b00)
                                 && (reg_idx == IDX_MATTR_C);
    wire logic       hit_md    = (paddr[11:10] == 2'b00)
                                 && (reg_idx == IDX_MATTR_D);
    wire logic       hit_me    = (paddr[11:10] == 2'b00)
                                 && (reg_idx == IDX_MATTR_E);
    wire logic       hit_sg    = (paddr[11:10] == 2'b00)
                                 && (reg_idx == IDX_SG_BASE);
    wire logic       hit_ctl   = (paddr[11:10] == 2'b00)
                                 && (reg_idx == IDX_MSEL_CTRL);
    wire logic       mapped    = hit_psel | hit_mc | hit_md
                                 | hit_me | hit_sg | hit_ctl;
    wire logic       setup_rd  = psel && !penable && !pwrite;
    wire logic       wr_go     = psel && penable && pwrite
                                 && mapped && pstrb[0];

    // Read mux, captured in setup so the answer comes from a flop
    wire logic [7:0] rd_byte   = hit_psel ? psel_b_r    :
                                 hit_mc   ? mattr_c_r   :
                                 hit_md   ? mattr_d_r   :
                                 hit_me   ? mattr_e_r   :
                                 hit_sg   ? sg_base_r   :
                                 hit_ctl  ? msel_ctrl_r : 8'h00;

    // Zero-wait slave: every access phase completes at once
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_r <= {24'h00_0000, rd_byte};
        end
    end

    // Register writes; reset loads the documented defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel_b_r    <= RST_PSEL_B;
            mattr_c_r   <= RST_MATTR;
            mattr_d_r   <= RST_MATTR;
            mattr_e_r   <= RST_MATTR;
            sg_base_r   <= RST_SG_BASE;
            msel_ctrl_r <= RST_MSEL_CTRL;
        end else if (wr_go) begin
            if (hit_psel) psel_b_r    <= pwdata[7:0];
            if (hit_mc)   mattr_c_r   <= pwdata[7:0];
            if (hit_md)   mattr_d_r   <= pwdata[7:0];
            if (hit_me)   mattr_e_r   <= pwdata[7:0];
            if (hit_sg)   sg_base_r   <= pwdata[7:0];
            if (hit_ctl)  msel_ctrl_r <= pwdata[7:0];
        end
    end

    // Request fields
    wire logic        io_req  = access_req.valid && access_req.io;
    wire logic        mem_req = access_req.valid && !access_req.io;
    wire logic [15:0] ioa     = access_req.addr[15:0];
    wire logic        io_top0 = (access_req.addr[31:16] == 16'h0000);

    // Configuration RAM decode
    wire logic cfg_en   = psel_b_r[BIT_CFG_EN];
    wire logic page_hit = io_req && io_top0 && access_req.write
                          && (ioa == IO_CFG_PAGE) && cfg_en;
    wire logic cmem_hit = io_req && io_top0
                          && (ioa[15:8] == IO_CFG_MEM_HI)
                          && cfg_en;

    // Port 92 and parallel port
    wire logic [1:0] lpt_sel = psel_b_r[LSB_LPT +: 2];
    wire logic p92_hit = io_req && io_top0 && (ioa == IO_PORT92)
                         && psel_b_r[BIT_P92_EN];
    wire logic lpt_in  = (lpt_sel == LPT_RANGE1) ? ioa[15:2] == IO_LPT1_BLK :
                         (lpt_sel == LPT_RANGE2) ? ioa[15:3] == IO_LPT2_BLK :
                         (lpt_sel == LPT_RANGE3) ? ioa[15:3] == IO_LPT3_BLK :
                         1'b0;
    wire logic lpt_hit = io_req && io_top0 && lpt_in;

    // Serial ports; B yields to A when both share a range
    wire logic [1:0] coma_sel = psel_b_r[LSB_COMA +: 2];
    wire logic [1:0] comb_sel = psel_b_r[LSB_COMB +: 2];
    wire logic coma_hit = io_req && io_top0
                          && com_hit(coma_sel, ioa);
    wire logic comb_hit = io_req && io_top0
                          && com_hit(comb_sel, ioa)
                          && (comb_sel != coma_sel);

    // Priority encode; a disabled device never reaches here
    wire logic [2:0] ecs_nxt = page_hit ? ECS_CFG_PAGE :
                               cmem_hit ? ECS_CFG_MEM  :
                               p92_hit  ? ECS_PORT92   :
                               lpt_hit  ? ECS_LPT      :
                               coma_hit ? ECS_COM_A    :
                               comb_hit ? ECS_COM_B    :
                               ECS_NONE;

    // Scatter/gather block relocated by the base register
    wire logic sg_nxt = io_req && io_top0 && (ioa[15:8] == sg_base_r)
                        && (ioa[7:0] >= SG_LOW_OFS)
                        && (ioa[7:0] < SG_END_OFS);

    // Memory segment lookup from A19:A14
    wire logic [5:0] seg_idx  = access_req.addr[19:14];
    wire logic       seg_zone = (access_req.addr[31:20] == 12'h000)
                                && (seg_idx[5:4] == SEG_TOP);
    wire logic [7:0] seg_reg  =
        (seg_idx[3:2] == SEG_BANK_C) ? mattr_c_r :
        (seg_idx[3:2] == SEG_BANK_D) ? mattr_d_r :
        (seg_idx[3:2] == SEG_BANK_E) ? mattr_e_r :
        8'h00;
    // Low pair of the register covers the lowest 16 KB segment
    wire logic [1:0] seg_pair = seg_reg[{seg_idx[1:0], 1'b0} +: 2];
    wire logic       seg_ok   = access_req.write ? seg_pair[1]
                                                 : seg_pair[0];
    wire logic mem_nxt = mem_req && seg_zone && seg_ok
                         && msel_ctrl_r[BIT_MSEL_EN];

    // Outputs registered one cycle after the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            encoded_device_select    <= ECS_NONE;
            utility_transceiver_oe_n <= 1'b1;
            config_page_select_n     <= 1'b1;
            config_memory_select_n   <= 1'b1;
            main_memory_select_n     <= 1'b1;
            sg_register_select       <= 1'b0;
        end else begin
            encoded_device_select    <= ecs_nxt;
            utility_transceiver_oe_n <= (ecs_nxt == ECS_NONE);
            config_page_select_n     <= !page_hit;
            config_memory_select_n   <= !cmem_hit;
            main_memory_select_n     <= !mem_nxt;
            sg_register_select       <= sg_nxt;
        end
    end

    // Base is a level, useful to the S/G register block as well
    assign sg_io_base = sg_base_r;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_sel_after(cause, eff);
        cause |=> eff;
    endproperty

    cfg_page_a: assert property (io_req && io_top0 && access_req.write
        && ioa == IO_CFG_PAGE && psel_b_r[BIT_CFG_EN]
        |=> !config_page_select_n
            && encoded_device_select == ECS_CFG_PAGE)
        else $error("config page select missing");
    cfg_mem_a: assert property (io_req && io_top0
        && ioa[15:8] == IO_CFG_MEM_HI && psel_b_r[BIT_CFG_EN]
        |=> !config_memory_select_n ##0 !utility_transceiver_oe_n)
        else $error("config memory select missing");
    cfg_off_a: assert property (p_sel_after(!psel_b_r[BIT_CFG_EN],
        config_page_select_n && config_memory_select_n))
        else $error("config select while decode off");
    port92_a: assert property (io_req && io_top0 && ioa == IO_PORT92
        |=> (encoded_device_select == ECS_PORT92)
            == $past(psel_b_r[BIT_P92_EN]))
        else $error("port 92 decode wrong");
    reset_val_a: assert property ($rose(presetn)
        |-> psel_b_r == RST_PSEL_B && sg_base_r == RST_SG_BASE)
        else $error("reset value wrong");
    lpt_off_a: assert property (p_sel_after(lpt_sel == 2'b11,
        encoded_device_select != ECS_LPT))
        else $error("parallel select while disabled");
    com_dup_a: assert property (p_sel_after(comb_sel == coma_sel,
        encoded_device_select != ECS_COM_B))
        else $error("serial B select with shared range");
    oe_match_a: assert property (utility_transceiver_oe_n
        == (encoded_device_select == ECS_NONE))
        else $error("transceiver enable mismatch");
    mem_off_a: assert property (p_sel_after(
        !msel_ctrl_r[BIT_MSEL_EN] || !mem_req, main_memory_select_n))
        else $error("memory select while off");
    mem_rd_a: assert property (mem_req && !access_req.write
        && access_req.addr[31:14] == 18'h00030 && mattr_c_r[0]
        && msel_ctrl_r[BIT_MSEL_EN] |=> !main_memory_select_n)
        else $error("segment read select missing");
    sg_hit_a: assert property (io_req && io_top0
        && ioa == {sg_base_r, SG_LOW_OFS} |=> sg_register_select)
        else $error("scatter/gather select missing");

    // Serial decode per range code; B only when it differs from A
    com_a_one_a: assert property (io_req && io_top0
        && coma_sel == COM_RANGE1 && ioa[15:3] == IO_COM1_BLK
        |=> encoded_device_select == ECS_COM_A)
        else $error("serial A first range missing");

    com_a_two_a: assert property (io_req && io_top0
        && coma_sel == COM_RANGE2 && ioa[15:3] == IO_COM2_BLK
        |=> encoded_device_select == ECS_COM_A)
        else $error("serial A second range missing");

    com_b_one_a: assert property (io_req && io_top0
        && comb_sel == COM_RANGE1 && coma_sel != COM_RANGE1
        && ioa[15:3] == IO_COM1_BLK
        |=> encoded_device_select == ECS_COM_B)
        else $error("serial B first range missing");

    // Reserved and disabled codes never select the port
    com_b_off_a: assert property (comb_sel[1]
        |=> encoded_device_select != ECS_COM_B)
        else $error("serial B select while off");

    com_a_off_a: assert property (coma_sel[1]
        |=> encoded_device_select != ECS_COM_A)
        else $error("serial A select while off");

    // Parallel port second range
    lpt_two_a: assert property (io_req && io_top0
        && lpt_sel == LPT_RANGE2 && ioa[15:3] == IO_LPT2_BLK
        |=> encoded_device_select == ECS_LPT)
        else $error("parallel select missing");

    // Page select answers writes only
    cfg_read_a: assert property (io_req && io_top0
        && !access_req.write && ioa == IO_CFG_PAGE
        |=> config_page_select_n)
        else $error("config page select on read");

    // No request, no select and no transceiver enable
    idle_quiet_a: assert property (!access_req.valid
        |=> utility_transceiver_oe_n && main_memory_select_n
            && !sg_register_select)
        else $error("select without request");

    // Segment lookups, one or more per attribute register
    mem_wr_a: assert property (mem_req && access_req.write
        && access_req.addr[31:14] == 18'h00035 && mattr_d_r[3]
        && msel_ctrl_r[BIT_MSEL_EN] |=> !main_memory_select_n)
        else $error("segment write select missing");

    mem_c_top_a: assert property (mem_req
        && !access_req.write
        && access_req.addr[31:14] == 18'h00033 && mattr_c_r[6]
        && msel_ctrl_r[BIT_MSEL_EN] |=> !main_memory_select_n)
        else $error("top C segment select missing");

    mem_d_low_a: assert property (mem_req
        && !access_req.write
        && access_req.addr[31:14] == 18'h00034 && mattr_d_r[0]
        && msel_ctrl_r[BIT_MSEL_EN] |=> !main_memory_select_n)
        else $error("low D segment select missing");

    mem_e_top_a: assert property (mem_req
        && !access_req.write
        && access_req.addr[31:14] == 18'h0003b && mattr_e_r[6]
        && msel_ctrl_r[BIT_MSEL_EN] |=> !main_memory_select_n)
        else $error("top E segment select missing");

    // Closed pair keeps the segment shut
    mem_shut_a: assert property (mem_req
        && seg_pair == 2'b00 |=> main_memory_select_n)
        else $error("select on closed segment");

    mem_no_rd_a: assert property (mem_req
        && !access_req.write && !seg_pair[0]
        |=> main_memory_select_n)
        else $error("read select without allow");

    // Outside C0000h-EFFFFh nothing is selected
    mem_zone_a: assert property (mem_req
        && (access_req.addr[31:16] < 16'h000c
            || access_req.addr[31:16] > 16'h000e)
        |=> main_memory_select_n)
        else $error("select outside segment zone");

    // Scatter/gather select follows the relocated page only
    sg_away_a: assert property (io_req
        && ioa[15:8] != sg_base_r |=> !sg_register_select)
        else $error("scatter/gather select off page");

    cfg_page_c: cover property (!config_page_select_n);
    lpt_sel_c:  cover property (encoded_device_select == ECS_LPT);
    com_b_c:    cover property (encoded_device_select == ECS_COM_B);
    mem_sel_c:  cover property (!main_memory_select_n);
    apb_wr_c:   cover property (wr_go ##1 setup_rd);

endmodule // pdcs_decode

`default_nettype wire

// ---- inc/pdcs_pkg.sv ----
// Shared constants and carriers for the peripheral decode block.
// Assumes an APB master in front and a decode-request source behind.
package pdcs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_PSEL_B      = 8'h4f;
    localparam logic [7:0]  IDX_MATTR_C     = 8'h54;
    localparam logic [7:0]  IDX_MATTR_D     = 8'h55;
    localparam logic [7:0]  IDX_MATTR_E     = 8'h56;
    localparam logic [7:0]  IDX_SG_BASE     = 8'h57;
    localparam logic [7:0]  IDX_MSEL_CTRL   = 8'h58;
    // Reset values
    localparam logic [7:0]  RST_PSEL_B      = 8'h4f;
    localparam logic [7:0]  RST_MATTR       = 8'h00;
    localparam logic [7:0]  RST_SG_BASE     = 8'h04;
    localparam logic [7:0]  RST_MSEL_CTRL   = 8'h00;
    // Field positions
    localparam int          BIT_CFG_EN      = 7;
    localparam int          BIT_P92_EN      = 6;
    localparam int          LSB_LPT         = 4;
    localparam int          LSB_COMB        = 2;
    localparam int          LSB_COMA        = 0;
    localparam int          BIT_MSEL_EN     = 4;
    // Field encodings
    localparam logic [1:0]  COM_RANGE1      = 2'b00;
    localparam logic [1:0]  COM_RANGE2      = 2'b01;
    localparam logic [1:0]  LPT_RANGE1      = 2'b00;
    localparam logic [1:0]  LPT_RANGE2      = 2'b01;
    localparam logic [1:0]  LPT_RANGE3      = 2'b10;
    // I/O addresses
    localparam logic [15:0] IO_CFG_PAGE     = 16'h0c00;
    localparam logic [7:0]  IO_CFG_MEM_HI   = 8'h08;
    localparam logic [15:0] IO_PORT92       = 16'h0092;
    localparam logic [12:0] IO_COM1_BLK     = 13'h007f;
    localparam logic [12:0] IO_COM2_BLK     = 13'h005f;
    localparam logic [13:0] IO_LPT1_BLK     = 14'h00ef;
    localparam logic [12:0] IO_LPT2_BLK     = 13'h006f;
    localparam logic [12:0] IO_LPT3_BLK     = 13'h004f;
    localparam logic [7:0]  SG_LOW_OFS      = 8'h10;
    localparam logic [7:0]  SG_END_OFS      = 8'h40;
    // Memory segment index (address bits 19:14) fields for the C, D and E banks
    localparam logic [1:0]  SEG_TOP         = 2'b11;
    localparam logic [1:0]  SEG_BANK_C      = 2'b00;
    localparam logic [1:0]  SEG_BANK_D      = 2'b01;
    localparam logic [1:0]  SEG_BANK_E      = 2'b10;
    // Encoded device selects
    localparam logic [2:0]  ECS_COM_A       = 3'h0;
    localparam logic [2:0]  ECS_COM_B       = 3'h1;
    localparam logic [2:0]  ECS_LPT         = 3'h2;
    localparam logic [2:0]  ECS_PORT92      = 3'h3;
    localparam logic [2:0]  ECS_CFG_PAGE    = 3'h4;
    localparam logic [2:0]  ECS_CFG_MEM     = 3'h5;
    localparam logic [2:0]  ECS_NONE        = 3'h7;

    // One decode request from a PCI, DMA or ISA master
    typedef struct packed {
        logic        valid;
        logic        io;
        logic        write;
        logic [31:0] addr;
    } pdcs_access_t;
endpackage

// ---- tb/pdcs_decode_bench.sv ----
// Self-checking bench for the peripheral decode block.
// Assumes pdcs_pkg is compiled first and a zero-wait APB slave.
`timescale 1ns/1ns
`default_nettype none

module pdcs_decode_bench;
    import pdcs_pkg::*;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0;
    logic [3:0]   pstrb = 4'hf;
    logic [31:0]  prdata;
    logic         pready, pslverr;
    pdcs_access_t req = '0;
    logic [2:0]   ecs, last_dev;
    logic         oe_n, page_n, cmem_n, mmem_n, sg_sel;
    logic [7:0]   sg_base;
    logic [31:0]  rd;
    logic         err;
    int           bad_count = 0;
    int           samples_checked = 0;

    // 50 MHz clock
    always #10 pclk = ~pclk;

    pdcs_decode DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .access_req(req), .encoded_device_select(ecs),
        .utility_transceiver_oe_n(oe_n), .config_page_select_n(page_n),
        .config_memory_select_n(cmem_n), .main_memory_select_n(mmem_n),
        .sg_register_select(sg_sel), .sg_io_base(sg_base));

    pdcs_xbus_model XBUS (.pclk(pclk), .dev_sel(ecs), .oe_n(oe_n),
        .last_dev(last_dev));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checked %0d, bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One APB transfer; the wait for pready is bounded
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 10);
        if (n >= 10) begin
            bad_count++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One request cycle, then judge the registered selects
    task automatic dec(input logic io, input logic wr, input logic [31:0] a,
                       input logic [2:0] e, input logic e_mem_n);
        @(posedge pclk);
        req <= '{valid: 1'b1, io: io, write: wr, addr: a};
        @(posedge pclk);
        req <= '0;
        @(negedge pclk);
        check("ecs", 32'(ecs), 32'(e));
        check("oe_n", 32'(oe_n), 32'(e == ECS_NONE));
        check("page_n", 32'(page_n), 32'(e != ECS_CFG_PAGE));
        check("cmem_n", 32'(cmem_n), 32'(e != ECS_CFG_MEM));
        check("mmem_n", 32'(mmem_n), 32'(e_mem_n));
    endtask

    task automatic s_reset();
        logic [7:0] ix [6];
        logic [7:0] ex [6];
        ix = '{8'h4f, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58};
        ex = '{8'h4f, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
        check("sg_base", 32'(sg_base), 32'h04);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ix[i], 8'h00);
            check("reset", rd, 32'(ex[i]));
        end
        // Unmapped place answers with an error and zero
        apb(1'b0, 8'h50, 8'h00);
        check("unmapped", {rd[30:0], err}, 32'h1);
    endtask

    task automatic s_serial();
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, IDX_PSEL_B, 8'(8'h3c | c));
            dec(1, 0, 32'h3ff, c == 0 ? ECS_COM_A : ECS_NONE, 1);
            dec(1, 1, 32'h2f8, c == 1 ? ECS_COM_A : ECS_NONE, 1);
            apb(1'b1, IDX_PSEL_B, 8'(8'h33 | (c << 2)));
            dec(1, 0, 32'h3f8, c == 0 ? ECS_COM_B : ECS_NONE, 1);
            dec(1, 0, 32'h2ff, c == 1 ? ECS_COM_B : ECS_NONE, 1);
        end
        // Shared range: port A wins, B stays silent; B answers once its range differs
        apb(1'b1, IDX_PSEL_B, 8'h30);
        dec(1, 0, 32'h3fc, ECS_COM_A, 1);
        dec(1, 0, 32'h3f7, ECS_NONE, 1);
        apb(1'b1, IDX_PSEL_B, 8'h35);
        dec(1, 1, 32'h2fa, ECS_COM_A, 1);
        apb(1'b1, IDX_PSEL_B, 8'h34);
        dec(1, 0, 32'h2f8, ECS_COM_B, 1);
        // Far side latches one edge after the select shows
        @(negedge pclk);
        check("xbus", 32'(last_dev), 32'(ECS_COM_B));
    endtask

    task automatic s_misc();
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, IDX_PSEL_B, 8'(8'h0f | (c << 4)));
            dec(1, 0, 32'h3bc, c == 0 ? ECS_LPT : ECS_NONE, 1);
            dec(1, 1, 32'h37f, c == 1 ? ECS_LPT : ECS_NONE, 1);
            dec(1, 0, 32'h278, c == 2 ? ECS_LPT : ECS_NONE, 1);
        end
        apb(1'b1, IDX_PSEL_B, 8'h7f);
        dec(1, 0, 32'h92, ECS_PORT92, 1);
        apb(1'b1, IDX_PSEL_B, 8'h3f);
        dec(1, 1, 32'h92, ECS_NONE, 1);
        dec(1, 1, 32'hc00, ECS_NONE, 1);
        dec(1, 0, 32'h800, ECS_NONE, 1);
        apb(1'b1, IDX_PSEL_B, 8'hbf);
        dec(1, 1, 32'hc00, ECS_CFG_PAGE, 1);
        dec(1, 0, 32'hc00, ECS_NONE, 1);
        dec(1, 0, 32'h800, ECS_CFG_MEM, 1);
        dec(1, 1, 32'h8ff, ECS_CFG_MEM, 1);
        dec(1, 0, 32'h900, ECS_NONE, 1);
    endtask

    task automatic s_memory();
        logic [31:0] a;
        apb(1'b1, IDX_MATTR_C, 8'h03);
        dec(0, 0, 32'hc0000, ECS_NONE, 1);
        apb(1'b1, IDX_MSEL_CTRL, 8'h10);
        for (int r = 0; r < 3; r++) begin
            for (int s = 0; s < 4; s++) begin
                a = 32'hc0000 + r * 32'h10000 + s * 32'h4000;
                apb(1'b1, 8'(IDX_MATTR_C + r), 8'(1 << (2 * s)));
                dec(0, 0, a + 32'h3fff, ECS_NONE, 0);
                dec(0, 1, a, ECS_NONE, 1);
                apb(1'b1, 8'(IDX_MATTR_C + r), 8'(2 << (2 * s)));
                dec(0, 1, a + 32'h2000, ECS_NONE, 0);
                dec(0, 0, a, ECS_NONE, 1);
                // Neighbours open, this pair shut
                apb(1'b1, 8'(IDX_MATTR_C + r), 8'(8'hff ^ (3 << (2 * s))));
                dec(0, 0, a + 32'h1000, ECS_NONE, 1);
                dec(0, 1, a, ECS_NONE, 1);
            end
        end
        apb(1'b1, IDX_MATTR_E, 8'hff);
        dec(0, 0, 32'hf0000, ECS_NONE, 1);
        dec(0, 0, 32'h1e0000, ECS_NONE, 1);
    endtask

    task automatic s_sg();
        apb(1'b1, IDX_SG_BASE, 8'ha5);
        // Write lands at the access edge; look once it has settled
        @(negedge pclk);
        check("sg_base", 32'(sg_base), 32'ha5);
        apb(1'b0, IDX_SG_BASE, 8'h00);
        check("sg_read", rd, 32'ha5);
        dec(1, 0, 32'ha510, ECS_NONE, 1);
        check("sg_sel", 32'(sg_sel), 32'h1);
        dec(1, 0, 32'ha50f, ECS_NONE, 1);
        check("sg_sel", 32'(sg_sel), 32'h0);
    endtask

    // Reset held six cycles, then each scenario in turn
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_serial();
        s_misc();
        s_memory();
        s_sg();
        conclude();
    end
endmodule // pdcs_decode_bench
`default_nettype wire

// ---- tb/pdcs_xbus_model.sv ----
// Utility-bus peripheral stand-in: remembers the last device selected.
// Assumes selects are registered levels that settle before each edge.
`timescale 1ns/1ns
`default_nettype none

module pdcs_xbus_model (
    input  wire logic       pclk,
    input  wire logic [2:0] dev_sel,
    input  wire logic       oe_n,
    output logic      [2:0] last_dev
);
    // Only trusted while the transceiver is on; idle codes are noise
    always_ff @(posedge pclk) begin
        if (!oe_n) last_dev <= dev_sel;
    end
endmodule // pdcs_xbus_model
`default_nettype wire
